// *** bench/asr_serial_tx.sv ***
// model: remote asynchronous transmitter driving the serial input line
`timescale 1ns/1ps
module asr_serial_tx #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk,
  output logic      line
);
  // ****
  // line driver
  // ****
  // line idles high between frames, as a real transmitter leaves it
  initial line = 1'b1;

  // one frame, lsb first; a zero stop level lets the bench build framing faults
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    int i;
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line <= stp;
    repeat (BIT_CLKS) @(posedge clk);
    line <= 1'b1;
    // one idle bit so the next falling edge is a clean one
    repeat (BIT_CLKS) @(posedge clk);
  endtask

  // short low pulse that must not survive the half-bit recheck
  task automatic glitch(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask
endmodule

// *** bench/tb_async_serial_receiver.sv ***
// testbench: register-level tests of the serial receiver against a line model
`timescale 1ns/1ps
module tb_async_serial_receiver;
  import asr_pkg::*;
  // ****
  // signals and instances
  // ****
  // divisor 1 gives two clocks a tick, sixteen ticks a bit
  localparam int BIT_CLKS = 32;
  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        rx_irq;
  logic        ev_irq;
  logic [31:0] rdv;
  logic        err;
  int          num_errors = 0;
  int          n_checks   = 0;
  logic [31:0] off_cfg [3] = '{32'h1, 32'h2, 32'h7};

  always #20 clk = ~clk;

  asr_rx DUT (
    .clk              (clk),
    .srst             (srst),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .serial_input_pin (rx_line),
    .rx_irq           (rx_irq),
    .ev_irq           (ev_irq)
  );

  asr_serial_tx #(.BIT_CLKS(BIT_CLKS)) u_tx (
    .clk  (clk),
    .line (rx_line)
  );

  // ****
  // tasks
  // ****
  // one apb transfer; an idle edge follows so the next call never re-drives psel
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stuck transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp=%h got=%h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // masked read compare; masking hides bits whose meaning is not fixed here
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv & m);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****
  // test sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped address
    rc(ADDR_CTRL, 32'hF, 32'h0, "ctrl_rst");
    rc(ADDR_BAUD, 32'hFFFF, 32'h000C, "baud_rst");
    rc(ADDR_STATUS, 32'h7, 32'h0, "status_rst");
    rc(ADDR_FLAGS, 32'h7, 32'h2, "flags_rst");
    wr(8'h40, 32'hFFFF_FFFF);
    chk("wr_slverr", 32'h1, {31'h0, err});
    rc(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped");
    chk("rd_slverr", 32'h1, {31'h0, err});
    done("reset");
    // plain character, flag set by hardware only
    wr(ADDR_BAUD, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h3);
    u_tx.send(9'h0A5, 8, 1'b1);
    rc(ADDR_FLAGS, 32'h1, 32'h1, "receive_flag_set");
    rc(ADDR_DATA, 32'h3FF, 32'h0A5, "data_a5");
    rc(ADDR_FLAGS, 32'h1, 32'h0, "receive_flag_clr");
    wr(ADDR_FLAGS, 32'h1);
    rc(ADDR_FLAGS, 32'h1, 32'h0, "receive_flag_wr");
    done("basic");
    // framing error, break, then a good stop clears the error
    u_tx.send(9'h03C, 8, 1'b0);
    rc(ADDR_DATA, 32'h3FF, 32'h23C, "framing_error_flag_set");
    u_tx.send(9'h000, 8, 1'b0);
    rc(ADDR_FLAGS, 32'h1, 32'h1, "brk_flag");
    rc(ADDR_DATA, 32'h3FF, 32'h200, "brk_data");
    u_tx.send(9'h0C3, 8, 1'b1);
    rc(ADDR_DATA, 32'h3FF, 32'h0C3, "framing_error_flag_clr");
    done("framing");
    // a false start is dropped silently and the receiver rearms
    wr(ADDR_CLEAR, 32'h7);
    u_tx.glitch(BIT_CLKS / 4);
    rc(ADDR_FLAGS, 32'h1, 32'h0, "glitch");
    rc(ADDR_STATUS, 32'h7, 32'h0, "glitch_framing_error_flag");
    u_tx.send(9'h055, 8, 1'b1);
    rc(ADDR_FLAGS, 32'h1, 32'h1, "rearm_no_en");
    chk("ev_masked", 32'h0, {31'h0, ev_irq});
    done("glitch");
    // interrupt enables, event enable and clear
    wr(ADDR_ENABLE, 32'h1);
    chk("ev_on", 32'h1, {31'h0, ev_irq});
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_IRQCTL, v[31:0]);
      chk("rx_irq", {31'h0, (v == 7)}, {31'h0, rx_irq});
    end
    rc(ADDR_DATA, 32'h3FF, 32'h055, "data_55");
    chk("rx_irq_off", 32'h0, {31'h0, rx_irq});
    wr(ADDR_CLEAR, 32'h1);
    chk("ev_off", 32'h0, {31'h0, ev_irq});
    rc(ADDR_STATUS, 32'h1, 32'h0, "status_clr");
    done("irq");
    // nine data bits
    wr(ADDR_CTRL, 32'hB);
    u_tx.send(9'h15A, 9, 1'b1);
    rc(ADDR_DATA, 32'h3FF, 32'h15A, "nine");
    done("nine");
    // any missing enable keeps the receiver off
    // the flag is gated by enable, so the sticky event shows whether a char landed
    wr(ADDR_CLEAR, 32'h7);
    foreach (off_cfg[i]) begin
      wr(ADDR_CTRL, off_cfg[i]);
      u_tx.send(9'h0FF, 8, 1'b1);
      rc(ADDR_FLAGS, 32'h1, 32'h0, "disabled");
      rc(ADDR_STATUS, 32'h7, 32'h0, "disabled_ev");
    end
    done("disabled");
    // third character overruns; reception blocked until enable toggles
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CLEAR, 32'h7);
    u_tx.send(9'h011, 8, 1'b1);
    u_tx.send(9'h022, 8, 1'b1);
    u_tx.send(9'h033, 8, 1'b1);
    rc(ADDR_FLAGS, 32'h5, 32'h5, "overrun");
    rc(ADDR_STATUS, 32'h4, 32'h4, "ovr_event");
    rc(ADDR_DATA, 32'h7FF, 32'h411, "fifo_0");
    rc(ADDR_DATA, 32'h3FF, 32'h022, "fifo_1");
    u_tx.send(9'h044, 8, 1'b1);
    rc(ADDR_FLAGS, 32'h1, 32'h0, "blocked");
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CTRL, 32'h3);
    rc(ADDR_FLAGS, 32'h4, 32'h0, "ovr_clr");
    u_tx.send(9'h066, 8, 1'b1);
    rc(ADDR_DATA, 32'h3FF, 32'h066, "after_clr");
    done("overrun");
    tally_and_finish();
  end

  // watchdog: the sequence needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog exp=done got=hang");
    tally_and_finish();
  end
endmodule

// *** rtl/asr_pkg.sv ***
// package: register map, field layout and timing constants of the serial receiver
package asr_pkg;

  // ***************************************************
  // register byte addresses
  // ***************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // receive_status_control
  localparam logic [7:0] ADDR_DATA    = 8'h04;  // receive_data_register
  localparam logic [7:0] ADDR_STATUS  = 8'h08;  // sticky event status
  localparam logic [7:0] ADDR_CLEAR   = 8'h0C;  // write-one-to-clear
  localparam logic [7:0] ADDR_ENABLE  = 8'h10;  // event enables
  localparam logic [7:0] ADDR_BAUD    = 8'h14;  // baud divisor
  localparam logic [7:0] ADDR_FLAGS   = 8'h18;  // peripheral_flag_register
  localparam logic [7:0] ADDR_IRQCTL  = 8'h1C;  // receive/peripheral/global enables

  // ***************************************************
  // control register fields
  // ***************************************************
  localparam int CTRL_CONTINUOUS_RECEIVE_ENABLE = 0;   // continuous_receive_enable
  localparam int CTRL_SERIAL_PORT_ENABLE = 1;   // serial_port_enable
  localparam int CTRL_SYNC = 2;   // clocked mode select
  localparam int CTRL_NINE = 3;   // nine data bits
  localparam int DATA_BIT9 = 8;   // ninth bit position in data read
  localparam int DATA_FRAMING_ERROR_FLAG = 9;   // framing_error_flag in data read
  localparam int DATA_OERR = 10;  // overrun in data read
  localparam int FLAGS_RECEIVE_FLAG = 0;  // receive_flag
  localparam int FLAGS_IDLE = 1;  // receiver_idle_flag
  localparam int FLAGS_OERR = 2;
  localparam int IRQ_RECEIVE_IRQ_ENABLE  = 0;   // receive_irq_enable
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE  = 1;   // peripheral_irq_enable
  localparam int IRQ_GIE   = 2;   // global_irq_enable

  // event bits: character received, framing error, overrun
  localparam int EV_W = 3;
  localparam int EV_RX   = 0;
  localparam int EV_FRAMING_ERROR_FLAG = 1;
  localparam int EV_OVR  = 2;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int          OVERSAMPLE  = 16;
  localparam logic [3:0]  HALF_TICK   = 4'h7;  // tick index at start-bit centre
  localparam logic [3:0]  LAST_TICK   = 4'hF;
  localparam logic [15:0] BAUD_RESET  = 16'h000C;  // arbitrary default divisor
  localparam int          FIFO_DEPTH  = 2;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [1:0] { RX_IDLE, RX_START, RX_DATA, RX_STOP } asr_state_t;

  typedef struct packed {
    logic       ovr;
    logic       framing_error_flag;
    logic       bit9;
    logic [7:0] data;
  } asr_char_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asr_apb_req_t;

endpackage

// *** rtl/asr_rx.sv ***
// module: asynchronous serial receiver with APB registers and two-entry buffer
`timescale 1ns/1ps

// Overview of operation
// - line sampled at sixteen ticks per bit; shift register moves once per bit
// - assembled character moves whole into a two-entry buffer
// - receiver runs only with continuous enable 1, clocked mode 0, port enable 1
// - falling edge of the input line starts a character; start bit is zero
// - start bit rechecked at half bit; if high, abandon silently and rearm
// - each data bit taken by majority vote one bit period later
// - stop bit sampled; zero sets framing error, one clears it
// - character pushed and receive flag raised at the centre of the stop bit
// - reading the data register returns and removes the oldest character
// - after overrun no further characters are accepted until cleared
// - receive flag high exactly while enabled and buffer holds a character
// - interrupt needs receive, peripheral and global enables all set
// - buffer and shift register are not visible in the register map
// - a break shows as flag set, framing error set, data zero
module asr_rx
  import asr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         serial_input_pin,
  output logic              rx_irq,
  output logic              ev_irq
);
  import asr_pkg::*;

  asr_apb_req_t req;
  asr_state_t   state_q, state_d;
  logic [3:0]   ctrl_q;
  logic [15:0]  baud_q, bcnt_q;
  logic [2:0]   irqctl_q;
  logic [EV_W-1:0] evst_q, even_q;
  logic [3:0]   tick_cnt_q;
  logic [3:0]   bit_cnt_q;
  logic [8:0]   shift_q;
  logic         line_q;
  logic         ovr_q;
  asr_char_t    fifo_q [FIFO_DEPTH];
  logic         rd_ptr_q, wr_ptr_q;
  logic [1:0]   count_q;
  logic [31:0]  rdata_q;
  logic         rd_head_q;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ***************************************************
  // bus decode
  // ***************************************************
  wire acc      = req.psel & req.penable;
  wire wr       = acc & req.pwrite;
  wire rd       = acc & ~req.pwrite;
  wire sel_ctrl = req.paddr == ADDR_CTRL;
  wire sel_data = req.paddr == ADDR_DATA;
  wire sel_stat = req.paddr == ADDR_STATUS;
  wire sel_clr  = req.paddr == ADDR_CLEAR;
  wire sel_en   = req.paddr == ADDR_ENABLE;
  wire sel_baud = req.paddr == ADDR_BAUD;
  wire sel_flag = req.paddr == ADDR_FLAGS;
  wire sel_irq  = req.paddr == ADDR_IRQCTL;
  wire mapped   = sel_ctrl | sel_data | sel_stat | sel_clr | sel_en | sel_baud
                | sel_flag | sel_irq;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = rdata_q;

  // ***************************************************
  // enable and oversample tick
  // ***************************************************
  wire rx_en = ctrl_q[CTRL_CONTINUOUS_RECEIVE_ENABLE] & ~ctrl_q[CTRL_SYNC] & ctrl_q[CTRL_SERIAL_PORT_ENABLE];
  wire continuous_receive_enable_off = wr & sel_ctrl & ~pwdata[CTRL_CONTINUOUS_RECEIVE_ENABLE];
  wire tick = rx_en & (bcnt_q == 16'h0000);
  wire vote;

  // divider reloads from the baud register; one tick is 1/16 bit
  always_ff @(posedge clk) begin
    if (srst || !rx_en || bcnt_q == 16'h0000) begin
      bcnt_q <= baud_q;
    end else begin
      bcnt_q <= bcnt_q - 16'h0001;
    end
  end

  asr_vote u_vote (
    .clk  (clk),
    .srst (srst),
    .tick (tick),
    .line (serial_input_pin),
    .vote (vote)
  );

  // ***************************************************
  // receive sequencer
  // ***************************************************
  wire fall     = tick & line_q & ~serial_input_pin;
  wire centre   = tick & (tick_cnt_q == HALF_TICK);
  wire bit_end  = tick & (tick_cnt_q == LAST_TICK);
  wire [3:0] nbits = ctrl_q[CTRL_NINE] ? 4'h9 : 4'h8;
  wire last_bit = bit_cnt_q == nbits - 4'h1;
  wire full     = count_q == 2'(FIFO_DEPTH);
  wire push     = (state_q == RX_STOP) & centre & ~ovr_q;
  wire pop      = rd & sel_data & rd_head_q;
  wire framing_error_flag_now = ~vote;

  always_comb begin
    state_d = state_q;
    case (state_q)
      RX_IDLE: begin
        if (fall && !ovr_q) begin
          state_d = RX_START;
        end
      end
      RX_START: begin
        if (centre) begin
          state_d = vote ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (centre && last_bit) begin
          state_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (centre) begin
          state_d = RX_IDLE;
        end
      end
      default: begin
        state_d = RX_IDLE;
      end
    endcase
  end

  // state, line history and tick position; leaving enable drops partial chars
  always_ff @(posedge clk) begin
    if (srst || !rx_en) begin
      state_q    <= RX_IDLE;
      tick_cnt_q <= 4'h0;
      line_q     <= 1'b1;
    end else begin
      state_q <= state_d;
      if (tick) begin
        line_q <= serial_input_pin;
      end
      if (state_q == RX_IDLE) begin
        tick_cnt_q <= 4'h0;
      end else if (tick) begin
        tick_cnt_q <= tick_cnt_q + 4'h1;
      end
    end
  end

  // shift register advances once per bit at the bit centre
  always_ff @(posedge clk) begin
    if (srst || state_q == RX_START) begin
      shift_q   <= 9'h000;
      bit_cnt_q <= 4'h0;
    end else if (state_q == RX_DATA && centre) begin
      shift_q   <= ctrl_q[CTRL_NINE] ? {vote, shift_q[8:1]}
                                     : {1'b0, vote, shift_q[7:1]};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // ***************************************************
  // two-entry buffer and overrun
  // ***************************************************
  wire push_ok  = push & (~full | pop);
  wire overflow = push & full & ~pop;

  always_ff @(posedge clk) begin
    if (push_ok) begin
      fifo_q[wr_ptr_q] <= '{ovr: 1'b0, framing_error_flag: framing_error_flag_now, bit9: shift_q[8],
                            data: shift_q[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      rd_ptr_q <= rd_ptr_q ^ pop;
      wr_ptr_q <= wr_ptr_q ^ push_ok;
      count_q  <= count_q + 2'(push_ok) - 2'(pop);
    end
  end

  // overrun sticks until continuous enable is written low
  // an overflow in the clearing cycle wins, so a lost character is never hidden
  always_ff @(posedge clk) begin
    if (srst) begin
      ovr_q <= 1'b0;
    end else if (overflow) begin
      ovr_q <= 1'b1;
    end else if (continuous_receive_enable_off) begin
      ovr_q <= 1'b0;
    end
  end

  // ***************************************************
  // software registers
  // ***************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q   <= 4'h0;
      baud_q   <= BAUD_RESET;
      irqctl_q <= 3'h0;
      even_q   <= '0;
    end else if (wr) begin
      if (sel_ctrl) ctrl_q <= pwdata[3:0];
      if (sel_baud) baud_q <= pwdata[15:0];
      if (sel_irq)  irqctl_q <= pwdata[2:0];
      if (sel_en)   even_q <= pwdata[EV_W-1:0];
    end
  end

  // sticky events; a set in the clearing cycle wins
  wire [EV_W-1:0] ev_set = {overflow, push_ok & framing_error_flag_now, push_ok};
  wire [EV_W-1:0] ev_clr = (wr & sel_clr) ? pwdata[EV_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (srst) begin
      evst_q <= '0;
    end else begin
      evst_q <= (evst_q & ~ev_clr) | ev_set;
    end
  end

  wire receive_flag = rx_en & (count_q != 2'h0);
  asr_char_t head;
  assign head = fifo_q[rd_ptr_q];
  wire [31:0] data_word = (count_q != 2'h0)
                        ? {21'h0, ovr_q, head.framing_error_flag, head.bit9, head.data}
                        : {21'h0, ovr_q, 10'h000};
  wire [31:0] rmux = sel_ctrl ? {28'h0, ctrl_q}
                   : sel_data ? data_word
                   : sel_stat ? {29'h0, evst_q}
                   : sel_en   ? {29'h0, even_q}
                   : sel_baud ? {16'h0, baud_q}
                   : sel_flag ? {29'h0, ovr_q, state_q == RX_IDLE, receive_flag}
                   : sel_irq  ? {29'h0, irqctl_q}
                   : 32'h0000_0000;

  // head presence latched at setup: a character pushed between setup and access
  // was not in the read word, so that read must not pop it
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_head_q <= 1'b0;
    end else if (psel && !penable) begin
      rd_head_q <= count_q != 2'h0;
    end
  end

  // read data registered at the setup cycle so it is stable in access
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rmux;
    end
  end

  assign rx_irq = receive_flag & irqctl_q[IRQ_RECEIVE_IRQ_ENABLE] & irqctl_q[IRQ_PERIPHERAL_IRQ_ENABLE] & irqctl_q[IRQ_GIE];
  assign ev_irq = |(evst_q & even_q);

  // ***************************************************
  // checks
  // ***************************************************
  chk_start_abort: assert property (@(posedge clk) disable iff (srst)
    (state_q == RX_START && centre && vote) |=> state_q == RX_IDLE && !push)
    else $error("false start not abandoned");
  chk_enable_gate: assert property (@(posedge clk) disable iff (srst)
    !rx_en |=> state_q == RX_IDLE)
    else $error("receiver ran while disabled");
  chk_flag_level: assert property (@(posedge clk) disable iff (srst)
    $changed(receive_flag) |-> $past(push_ok) || $past(pop) || $changed(rx_en))
    else $error("receive flag moved without buffer or enable change");
  chk_push_flag: assert property (@(posedge clk) disable iff (srst)
    push_ok |=> receive_flag || !rx_en)
    else $error("flag not raised after push");
  chk_fifo_bound: assert property (@(posedge clk) disable iff (srst)
    count_q <= 2'(FIFO_DEPTH))
    else $error("buffer count exceeds depth");
  chk_pop_count: assert property (@(posedge clk) disable iff (srst)
    (pop && !push_ok) |=> count_q == $past(count_q) - 2'h1)
    else $error("read did not remove a character");
  chk_ovr_block: assert property (@(posedge clk) disable iff (srst)
    ovr_q |-> !push_ok && state_q == RX_IDLE)
    else $error("character accepted during overrun");
  chk_irq_gate: assert property (@(posedge clk) disable iff (srst)
    rx_irq |-> receive_flag && irqctl_q == 3'h7)
    else $error("interrupt without all enables");
  chk_framing_error_flag_store: assert property (@(posedge clk) disable iff (srst)
    (push_ok && !vote) |=> evst_q[EV_FRAMING_ERROR_FLAG])
    else $error("framing error not recorded");
  chk_continuous_receive_enable_clear: assert property (@(posedge clk) disable iff (srst)
    continuous_receive_enable_off |=> ovr_q == $past(overflow))
    else $error("overrun not cleared by enable off");

  // sequencer pacing and bookkeeping
  chk_start_hold: assert property (@(posedge clk) disable iff (srst)
    (state_q == RX_IDLE && fall && !ovr_q) |=> state_q == RX_START || !rx_en)
    else $error("falling edge did not start a character");
  chk_bit_step: assert property (@(posedge clk) disable iff (srst)
    (state_q == RX_DATA && !centre) |=> $stable(bit_cnt_q))
    else $error("shift register moved between bit centres");
  chk_bit_centre: assert property (@(posedge clk) disable iff (srst)
    (state_q == RX_DATA && centre) |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
    else $error("data bit not taken at bit centre");
  chk_tick_gap: assert property (@(posedge clk) disable iff (srst)
    (tick && baud_q != 16'h0000) |=> !tick)
    else $error("oversample ticks too close");
  chk_ovr_set: assert property (@(posedge clk) disable iff (srst)
    overflow |=> ovr_q)
    else $error("overflow did not set overrun");
  chk_irq_level: assert property (@(posedge clk) disable iff (srst)
    (receive_flag && irqctl_q == 3'h7) |-> rx_irq)
    else $error("interrupt missing with all enables set");
  chk_break_event: assert property (@(posedge clk) disable iff (srst)
    (push_ok && !vote && shift_q[7:0] == 8'h00) |=> evst_q[EV_RX] && evst_q[EV_FRAMING_ERROR_FLAG])
    else $error("break not shown as character with framing error");

  // covers: one each for the basic, break, glitch, nine and overrun scenarios of the bench

  cov_char: cover property (@(posedge clk) disable iff (srst) push_ok);
  cov_abort: cover property (@(posedge clk) disable iff (srst)
    state_q == RX_START && centre && vote);
  cov_overrun: cover property (@(posedge clk) disable iff (srst) overflow);
  cov_break: cover property (@(posedge clk) disable iff (srst)
    push_ok && !vote && shift_q[7:0] == 8'h00);
  cov_nine: cover property (@(posedge clk) disable iff (srst) push_ok && ctrl_q[CTRL_NINE]);
endmodule

// *** rtl/asr_vote.sv ***
// module: three-sample majority vote over the oversampled line
`timescale 1ns/1ps
module asr_vote (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       tick,
  input  wire logic       line,
  output logic            vote
);
  logic [2:0] hist_q;

  // ***************************************************
  // sample history, one entry per oversample tick
  // ***************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      hist_q <= 3'h7;
    end else if (tick) begin
      hist_q <= {hist_q[1:0], line};
    end
  end

  // two of three wins, so a single glitch sample cannot flip the bit
  assign vote = (hist_q[0] & hist_q[1]) | (hist_q[0] & hist_q[2]) | (hist_q[1] & hist_q[2]);
endmodule
